/* File: adcch_cfg.svh */
// Offsets, field positions and reset values of the converter channel registers
`ifndef ADCCH_CFG_SVH
`define ADCCH_CFG_SVH
// Register indices, byte address is four times the index
`define ADCCH_IDX_CTRL      8'h00
`define ADCCH_IDX_MUX       8'h01
`define ADCCH_IDX_RESL      8'h04
`define ADCCH_IDX_RESH      8'h05
`define ADCCH_IDX_TEMP      8'h07
`define ADCCH_IDX_COMPARE_VALUE_LOW      8'h18
`define ADCCH_IDX_COMPARE_VALUE_HIGH      8'h19
// Field position, reserved gain code and last valid pin and source codes
`define ADCCH_START_BIT     7
`define ADCCH_GAIN_RESERVED 3'h7
`define ADCCH_PIN_LAST      4'hB
`define ADCCH_INT_LAST      4'h3
// Reset values
`define ADCCH_RST_BYTE      8'h00
`define ADCCH_RST_WORD      16'h0000
`endif

/* File: adcch_pkg.sv */
// Types shared by the converter channel register block
`default_nettype none
package adcch_pkg;
    // Result packing chosen by the module-wide control
    typedef enum logic [1:0] {
        ADCCH_FMT_12R = 2'h0,
        ADCCH_FMT_12L = 2'h1,
        ADCCH_FMT_8   = 2'h2
    } adcch_fmt_t;
    // Channel input mode codes
    typedef enum logic [1:0] {
        ADCCH_MODE_INTERNAL = 2'h0,
        ADCCH_MODE_SINGLE   = 2'h1,
        ADCCH_MODE_DIFFERENTIAL_INPUT     = 2'h2,
        ADCCH_MODE_DIFFG    = 2'h3
    } adcch_mode_t;
    // Whole state of the channel
    typedef struct packed {
        logic        rdy;
        logic [31:0] prdata;
        logic        pslverr;
        logic        start;
        logic [2:0]  gain;
        adcch_mode_t mode;
        logic [3:0]  pos;
        logic [1:0]  neg;
        logic [15:0] cmp;
        logic [15:0] res;
        logic [7:0]  temp;
        logic        discard;
        logic [3:0]  pos_pin;
        logic        pos_ok;
        logic [1:0]  int_src;
        logic        int_ok;
        logic [2:0]  neg_pin;
        logic        neg_ok;
        logic        gain_on;
    } adcch_state_t;
endpackage
`default_nettype wire

/* File: adcch_channel.sv */
// One converter channel: control, input select, compare value and result packing
// Behaviour
// - Left 12-bit: result bits 11:4 in high byte
// - Right 12-bit: bits 11:8 low nibble, top sign-extended in signed differential modes, else zero
// - 8-bit: high byte is sign copies or zero
// - Right 12-bit and 8-bit: low byte bits 7:0
// - Left 12-bit: bits 3:0 in low-byte top nibble
// - Read-write 16-bit compare value at 0x18/0x19
// - Start bit launches, self-clears, re-set harmless
// - Module-wide start view shares this storage
// - Gain codes 1x to 64x, code 111 reserved
// - Unsigned: internal or single pin modes only
// - Signed adds differential and gained differential
// - Input mode change discards pipeline results
// - Internal sources selected by codes 0000 to 0011
// - Single or differential: pins 0 to 11
// - Gained differential: pins 0 to 7 only
// - Result value read-only, zero after reset
// - Negative pin used only in differential modes
// - Low-byte read latches high byte into temp
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "adcch_cfg.svh"
module adcch_channel (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [9:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 signed_conversion_select,
    input  wire adcch_pkg::adcch_fmt_t result_format,
    input  wire logic                 module_start_set,
    input  wire logic                 conv_started,
    input  wire logic                 conv_done,
    input  wire logic [11:0]          conv_result,
    output logic                      start_request,
    output logic [2:0]                gain_select,
    output logic                      gain_stage_on,
    output adcch_pkg::adcch_mode_t    input_source_mode,
    output logic [1:0]                internal_source,
    output logic                      internal_source_valid,
    output logic [3:0]                positive_pin,
    output logic                      positive_pin_valid,
    output logic [2:0]                negative_pin,
    output logic                      negative_pin_valid,
    output logic [15:0]               compare_value,
    output logic [15:0]               channel_result_value,
    output logic                      pipeline_discard
);
    import adcch_pkg::*;

    adcch_state_t s_reg;          // Registered state
    adcch_state_t s_next;         // Next state
    logic         acc_done;       // Access phase completes this edge
    logic         wr;             // Completing write
    logic         rd;             // Completing read
    logic [7:0]   idx;            // Register index from byte address
    logic [7:0]   rdval;          // Read data for the setup phase
    logic         mapped;         // Index hits a register
    logic         start_set;      // Any request to set the start bit
    logic         ext12;          // Sign fill for right-adjusted 12-bit
    logic         ext8;           // Sign fill for 8-bit results

    // Outputs are taken straight from the state flops
    assign prdata                = s_reg.prdata;
    assign pready                = s_reg.rdy;
    assign pslverr               = s_reg.pslverr;
    assign start_request         = s_reg.start;
    assign gain_select           = s_reg.gain;
    assign gain_stage_on         = s_reg.gain_on;
    assign input_source_mode     = s_reg.mode;
    assign internal_source       = s_reg.int_src;
    assign internal_source_valid = s_reg.int_ok;
    assign positive_pin          = s_reg.pos_pin;
    assign positive_pin_valid    = s_reg.pos_ok;
    assign negative_pin          = s_reg.neg_pin;
    assign negative_pin_valid    = s_reg.neg_ok;
    assign compare_value         = s_reg.cmp;
    assign channel_result_value  = s_reg.res;
    assign pipeline_discard      = s_reg.discard;

    // All next-state logic
    always_comb begin
        s_next         = s_reg;
        s_next.discard = 1'b0;
        s_next.rdy     = 1'b0;
        idx            = paddr[9:2];
        acc_done       = psel && penable && s_reg.rdy;
        wr             = acc_done && pwrite;
        rd             = acc_done && !pwrite;
        mapped         = 1'b1;
        rdval          = `ADCCH_RST_BYTE;
        // Read mux; reserved bits read as zero
        case (idx)
            `ADCCH_IDX_CTRL: begin
                rdval = {s_reg.start, 2'h0, s_reg.gain, s_reg.mode};
            end
            `ADCCH_IDX_MUX: begin
                rdval = {1'b0, s_reg.pos, 1'b0, s_reg.neg};
            end
            `ADCCH_IDX_RESL: begin
                rdval = s_reg.res[7:0];
            end
            `ADCCH_IDX_RESH: begin
                rdval = s_reg.temp; // Coherent half of the pair
            end
            `ADCCH_IDX_TEMP: begin
                rdval = s_reg.temp;
            end
            `ADCCH_IDX_COMPARE_VALUE_LOW: begin
                rdval = s_reg.cmp[7:0];
            end
            `ADCCH_IDX_COMPARE_VALUE_HIGH: begin
                rdval = s_reg.temp; // Same latch serves the compare pair
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        // Setup phase: answer is prepared, pready rises next edge
        if (psel && !penable && !s_reg.rdy) begin
            s_next.rdy     = 1'b1;
            s_next.pslverr = !mapped;
            s_next.prdata  = {24'h000000, rdval};
        end
        // Writes take effect only on the completing edge
        if (wr && mapped) begin
            case (idx)
                `ADCCH_IDX_CTRL: begin
                    s_next.gain = pwdata[4:2];
                    s_next.mode = adcch_mode_t'(pwdata[1:0]);
                    if (pwdata[1:0] != s_reg.mode) begin
                        s_next.discard = 1'b1;
                    end
                end
                `ADCCH_IDX_MUX: begin
                    s_next.pos = pwdata[6:3];
                    s_next.neg = pwdata[1:0];
                end
                `ADCCH_IDX_TEMP: begin
                    s_next.temp = pwdata[7:0];
                end
                `ADCCH_IDX_COMPARE_VALUE_LOW: begin
                    s_next.cmp[7:0] = pwdata[7:0];
                end
                `ADCCH_IDX_COMPARE_VALUE_HIGH: begin
                    s_next.cmp[15:8] = pwdata[7:0];
                end
                default: begin
                    // Result registers ignore writes
                end
            endcase
        end
        // Low-byte reads freeze the high byte for the next read
        if (rd && idx == `ADCCH_IDX_RESL) begin
            s_next.temp = s_reg.res[15:8];
        end
        if (rd && idx == `ADCCH_IDX_COMPARE_VALUE_LOW) begin
            s_next.temp = s_reg.cmp[15:8];
        end
        // One storage bit for both start views; set wins over clear
        start_set = module_start_set
                  || (wr && idx == `ADCCH_IDX_CTRL && pwdata[`ADCCH_START_BIT]);
        if (start_set) begin
            s_next.start = 1'b1; // Setting while set is harmless
        end else if (conv_started) begin
            s_next.start = 1'b0;
        end
        // Result packing on completion
        ext12 = signed_conversion_select && s_reg.mode[1] && conv_result[11];
        ext8  = signed_conversion_select && conv_result[7];
        if (conv_done) begin
            case (result_format)
                ADCCH_FMT_12L: begin
                    s_next.res = {conv_result, 4'h0};
                end
                ADCCH_FMT_8: begin
                    s_next.res = {{8{ext8}}, conv_result[7:0]};
                end
                default: begin
                    s_next.res = {{4{ext12}}, conv_result};
                end
            endcase
        end
        // Internal sources, any conversion mode
        s_next.int_src = s_next.pos[1:0];
        s_next.int_ok  = (s_next.mode == ADCCH_MODE_INTERNAL)
                       && (s_next.pos <= `ADCCH_INT_LAST);
        // Positive pin; differential codes need signed mode
        s_next.pos_pin = s_next.pos;
        case (s_next.mode)
            ADCCH_MODE_SINGLE: begin
                s_next.pos_ok = s_next.pos <= `ADCCH_PIN_LAST;
            end
            ADCCH_MODE_DIFFERENTIAL_INPUT: begin
                s_next.pos_ok = signed_conversion_select
                              && (s_next.pos <= `ADCCH_PIN_LAST);
            end
            ADCCH_MODE_DIFFG: begin
                s_next.pos_ok = signed_conversion_select && !s_next.pos[3];
            end
            default: begin
                s_next.pos_ok = 1'b0;
            end
        endcase
        // Negative pin: upper group in gained differential mode, whatever the gain code
        s_next.neg_pin = {s_next.mode == ADCCH_MODE_DIFFG, s_next.neg};
        s_next.neg_ok  = signed_conversion_select && s_next.mode[1];
        // Gain only in gained differential; reserved code disables it
        s_next.gain_on = signed_conversion_select
                       && (s_next.mode == ADCCH_MODE_DIFFG)
                       && (s_next.gain != `ADCCH_GAIN_RESERVED);
    end

    // State register; clock enable freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Completing write to the control register
    sequence s_ctrl_wr;
        clk_en && psel && penable && pready && pwrite && idx == `ADCCH_IDX_CTRL;
    endsequence
    // Completing read of the low result byte
    sequence s_resl_rd;
        clk_en && psel && penable && pready && !pwrite && idx == `ADCCH_IDX_RESL;
    endsequence
    // Setup phase seen by an idle slave
    sequence s_setup;
        clk_en && psel && !penable && !pready;
    endsequence

    // Answer one cycle after setup, for one cycle only
    a_apb_answer: assert property (s_setup |=> pready ##0 (pslverr == !$past(mapped)))
        else $error("no answer one cycle after setup");
    a_ready_pulse: assert property (clk_en && pready |=> !pready)
        else $error("ready held too long");
    // Holes answer with an error and zero data
    a_unmapped: assert property (s_setup ##0 !mapped
        |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    // Start bit: set by either view, held until launch, set wins over clear
    a_start_set: assert property (s_ctrl_wr ##0 pwdata[7] |=> start_request)
        else $error("start bit not set by write");
    a_start_clear: assert property (clk_en && conv_started && !start_set
        |=> !start_request)
        else $error("start bit not cleared on launch");
    a_start_hold: assert property (clk_en && start_request && !conv_started
        |=> start_request)
        else $error("start bit dropped before launch");
    a_start_view: assert property (clk_en && module_start_set && conv_started
        |=> start_request)
        else $error("shared start view lost a set");
    a_start_cause: assert property (clk_en && !start_request && !start_set
        |=> !start_request)
        else $error("start bit rose without a set");

    // Result packing per format, one cycle after completion
    a_res_left: assert property (clk_en && conv_done
        && result_format == ADCCH_FMT_12L
        |=> channel_result_value == {$past(conv_result), 4'h0})
        else $error("left adjusted packing wrong");
    a_res_right: assert property (clk_en && conv_done
        && result_format == ADCCH_FMT_12R
        |=> channel_result_value[11:0] == $past(conv_result)
        && channel_result_value[15:12] == {4{$past(signed_conversion_select)
        && $past(input_source_mode[1]) && $past(conv_result[11])}})
        else $error("right adjusted packing wrong");
    a_res_byte: assert property (clk_en && conv_done
        && result_format == ADCCH_FMT_8
        |=> channel_result_value[7:0] == $past(conv_result[7:0])
        && channel_result_value[15:8] == {8{$past(signed_conversion_select)
        && $past(conv_result[7])}})
        else $error("8-bit packing wrong");
    a_res_hold: assert property (clk_en && !conv_done
        |=> $stable(channel_result_value))
        else $error("result changed without conversion");

    // Compare value bytes land on the completing write
    a_cmp_low: assert property (clk_en && psel && penable && pready && pwrite
        && idx == `ADCCH_IDX_COMPARE_VALUE_LOW |=> compare_value[7:0] == $past(pwdata[7:0]))
        else $error("compare low byte not written");
    a_cmp_high: assert property (clk_en && psel && penable && pready && pwrite
        && idx == `ADCCH_IDX_COMPARE_VALUE_HIGH |=> compare_value[15:8] == $past(pwdata[7:0]))
        else $error("compare high byte not written");

    // Mode change discards the pipeline; nothing else moves the mode
    a_mode_discard: assert property (s_ctrl_wr
        ##0 (pwdata[1:0] != input_source_mode) |=> pipeline_discard)
        else $error("mode change did not discard");
    a_mode_hold: assert property (clk_en && !(psel && penable && pready
        && pwrite && idx == `ADCCH_IDX_CTRL) |=> $stable(input_source_mode)
        && !pipeline_discard)
        else $error("mode moved without a control write");

    // Coherent result pair: low read latches, high read returns the latch
    a_temp_latch: assert property (s_resl_rd
        |=> s_reg.temp == $past(channel_result_value[15:8]))
        else $error("high byte not latched on low read");
    a_resh_read: assert property (s_setup ##0 idx == `ADCCH_IDX_RESH
        |=> prdata[7:0] == $past(s_reg.temp))
        else $error("high result byte not from latch");

    // Decode: valid selections never point at reserved codes
    a_int_range: assert property (internal_source_valid
        |-> input_source_mode == ADCCH_MODE_INTERNAL
        && positive_pin <= `ADCCH_INT_LAST && internal_source == positive_pin[1:0])
        else $error("internal source outside its codes");
    a_pin_range: assert property (positive_pin_valid
        |-> input_source_mode != ADCCH_MODE_INTERNAL && positive_pin <= `ADCCH_PIN_LAST)
        else $error("positive pin on a reserved code");
    a_gain_pins: assert property (positive_pin_valid
        && input_source_mode == ADCCH_MODE_DIFFG |-> !positive_pin[3])
        else $error("gained input beyond pin 7");
    a_unsigned_pins: assert property (clk_en && !signed_conversion_select
        |=> !negative_pin_valid && !gain_stage_on
        && !(positive_pin_valid && input_source_mode[1]))
        else $error("differential selection in unsigned mode");
    a_differential_input_pins: assert property (clk_en && signed_conversion_select
        |=> positive_pin_valid || !input_source_mode[1] || positive_pin[3])
        else $error("differential pin not selected");
    a_gain_valid: assert property (gain_stage_on
        |-> input_source_mode == ADCCH_MODE_DIFFG && gain_select != `ADCCH_GAIN_RESERVED)
        else $error("gain stage on outside gained differential");
    a_neg_differential_input: assert property (negative_pin_valid
        |-> input_source_mode[1] && negative_pin[2] == input_source_mode[0])
        else $error("negative pin outside differential");
endmodule
`default_nettype wire

/* File: adcch_pipe_model.sv */
// Behavioural model of the analog pipeline behind one converter channel
`timescale 1ns/1ps
`default_nettype none
module adcch_pipe_model #(
    parameter int LAT = 5 // Cycles from launch to result
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        stall,
    input  wire logic        start_request,
    input  wire logic [11:0] next_result,
    output logic             conv_started,
    output logic             conv_done,
    output logic [11:0]      conv_result
);
    int          cnt_reg;  // Cycles left, zero when idle
    logic [11:0] last_reg; // Last value put on the result bus
    // One conversion at a time; stall holds a request back to test slow answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg      <= 0;
            last_reg     <= 12'h000;
            conv_started <= 1'h0;
            conv_done    <= 1'h0;
            conv_result  <= 12'hFFF;
        end else begin
            conv_started <= 1'h0;
            conv_done    <= 1'h0;
            // Bus not valid outside the done pulse, so never show the old value
            conv_result  <= ~last_reg;
            if (cnt_reg == 0) begin
                if (start_request && !stall) begin
                    conv_started <= 1'h1;
                    cnt_reg      <= LAT;
                end
            end else if (cnt_reg == 1) begin
                conv_done   <= 1'h1;
                conv_result <= next_result;
                last_reg    <= next_result;
                cnt_reg     <= 0;
            end else begin
                cnt_reg <= cnt_reg - 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: adc_channel_config_result_test.sv */
// Self-checking bench for the converter channel register block
`timescale 1ns/1ps
`default_nettype none
`include "adcch_cfg.svh"
module adc_channel_config_result_test;
    import adcch_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, sgn, mset, stall; // Bench drives
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic pready, pslverr, err, start_request, gain_stage_on, pipeline_discard;
    logic internal_source_valid, positive_pin_valid, negative_pin_valid;
    logic conv_started, conv_done;
    logic [11:0] raw, conv_result;
    logic [2:0]  gain_select, negative_pin;
    logic [1:0]  internal_source;
    logic [3:0]  positive_pin;
    logic [15:0] compare_value, channel_result_value, ev;
    adcch_fmt_t  fmt;
    adcch_mode_t input_source_mode;
    int num_errors = 0, compares = 0, disc = 0, dones = 0, d0;
    logic [16:0] ptab [7] = '{{2'h1, 1'h0, 2'h1, 12'hABC}, {2'h0, 1'h1, 2'h2, 12'h9A5},
        {2'h0, 1'h1, 2'h1, 12'h9A5}, {2'h0, 1'h1, 2'h3, 12'h7FF}, {2'h2, 1'h1, 2'h2, 12'h085},
        {2'h2, 1'h0, 2'h1, 12'h085}, {2'h1, 1'h1, 2'h2, 12'h801}}; // Format, sign, mode, raw
    logic [8:0] mtab [9] = '{{1'h0, 2'h0, 4'h3, 2'h0}, {1'h0, 2'h0, 4'h4, 2'h0},
        {1'h0, 2'h1, 4'hB, 2'h2}, {1'h0, 2'h1, 4'hC, 2'h1}, {1'h1, 2'h3, 4'h7, 2'h3},
        {1'h1, 2'h3, 4'h8, 2'h1}, {1'h1, 2'h2, 4'hB, 2'h3}, {1'h0, 2'h2, 4'h5, 2'h2},
        {1'h1, 2'h2, 4'hC, 2'h0}}; // Sign, mode, positive, negative
    logic [1:0] m, prev;
    logic [3:0] p;
    logic pv, iv;
    adcch_channel i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .signed_conversion_select(sgn),
        .result_format(fmt), .module_start_set(mset), .conv_started(conv_started),
        .conv_done(conv_done), .conv_result(conv_result), .start_request(start_request),
        .gain_select(gain_select), .gain_stage_on(gain_stage_on),
        .input_source_mode(input_source_mode), .internal_source(internal_source),
        .internal_source_valid(internal_source_valid), .positive_pin(positive_pin),
        .positive_pin_valid(positive_pin_valid), .negative_pin(negative_pin),
        .negative_pin_valid(negative_pin_valid), .compare_value(compare_value),
        .channel_result_value(channel_result_value), .pipeline_discard(pipeline_discard));
    adcch_pipe_model i_pipe (.pclk(pclk), .presetn(presetn), .stall(stall),
        .start_request(start_request), .next_result(raw), .conv_started(conv_started),
        .conv_done(conv_done), .conv_result(conv_result));
    // 100 MHz clock
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    // Count discard and completion pulses for the sequence checks
    always @(posedge pclk) begin
        if (pipeline_discard === 1'h1) disc++;
        if (conv_done === 1'h1) dones++;
    end
    task automatic final_report;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits on pready with a bound so a dead slave cannot hang
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        rdv     = prdata;
        err     = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            num_errors++;
            final_report();
        end
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'h0, idx, 8'h00);
        check({err, rdv}, {1'h0, 24'h0, exp});
    endtask
    // Bounded wait for the pipeline to hand back a result
    task automatic wait_done;
        int n = 0;
        while (conv_done !== 1'h1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        if (n >= 100) begin
            num_errors++;
            final_report();
        end
    endtask
    function automatic logic [15:0] pack(input logic [1:0] f, input logic s,
                                         input logic [1:0] md, input logic [11:0] r);
        if (f == 2'h1) return {r, 4'h0};
        if (f == 2'h2) return {{8{s & r[7]}}, r[7:0]};
        return {{4{s & md[1] & r[11]}}, r};
    endfunction
    initial begin
        {psel, penable, pwrite, sgn, mset, stall, presetn} = 7'h00;
        paddr = 10'h000;
        pwdata = 32'h0;
        raw = 12'h000;
        fmt = ADCCH_FMT_12R;
        prev = 2'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        // Reset values, then read-only result and unmapped place
        rd(`ADCCH_IDX_CTRL, 8'h00);
        rd(`ADCCH_IDX_MUX, 8'h00);
        apb(1'h1, `ADCCH_IDX_RESL, 8'hFF);
        rd(`ADCCH_IDX_RESL, 8'h00);
        rd(`ADCCH_IDX_RESH, 8'h00);
        apb(1'h0, 8'h30, 8'h00);
        check({err, rdv}, 33'h100000000);
        // Compare pair; high byte rewritten after the low read still reads latched copy
        apb(1'h1, `ADCCH_IDX_COMPARE_VALUE_LOW, 8'h34);
        apb(1'h1, `ADCCH_IDX_COMPARE_VALUE_HIGH, 8'h12);
        @(posedge pclk);
        check(compare_value, 32'h1234);
        rd(`ADCCH_IDX_COMPARE_VALUE_LOW, 8'h34);
        apb(1'h1, `ADCCH_IDX_COMPARE_VALUE_HIGH, 8'h56);
        rd(`ADCCH_IDX_COMPARE_VALUE_HIGH, 8'h12);
        @(posedge pclk);
        check(compare_value, 32'h5634);
        // Result packing in every format, launched by the start bit
        foreach (ptab[i]) begin
            fmt <= adcch_fmt_t'(ptab[i][16:15]);
            sgn <= ptab[i][14];
            m = ptab[i][13:12];
            raw <= ptab[i][11:0];
            d0 = disc;
            apb(1'h1, `ADCCH_IDX_CTRL, {6'h20, m});
            wait_done();
            check(disc - d0, m != prev);
            check(start_request, 1'h0);
            ev = pack(ptab[i][16:15], ptab[i][14], m, ptab[i][11:0]);
            check(channel_result_value, ev);
            rd(`ADCCH_IDX_RESL, ev[7:0]);
            rd(`ADCCH_IDX_RESH, ev[15:8]);
            prev = m;
        end
        // Module-wide start shares the bit; a second set while pending does nothing
        stall <= 1'h1;
        @(posedge pclk);
        mset <= 1'h1;
        @(posedge pclk);
        mset <= 1'h0;
        rd(`ADCCH_IDX_CTRL, {6'h20, prev});
        apb(1'h1, `ADCCH_IDX_CTRL, {6'h20, prev});
        d0 = dones;
        stall <= 1'h0;
        wait_done();
        repeat (12) @(posedge pclk);
        check(dones - d0, 1);
        rd(`ADCCH_IDX_CTRL, {6'h00, prev});
        // Module-wide set on the very launch edge wins and launches once more
        d0 = dones;
        apb(1'h1, `ADCCH_IDX_CTRL, {6'h20, prev});
        @(posedge pclk);
        mset <= 1'h1;
        @(posedge pclk);
        mset <= 1'h0;
        repeat (30) @(posedge pclk);
        check(dones - d0, 2);
        check(start_request, 1'h0);
        // Input selection decode for every mode
        foreach (mtab[i]) begin
            sgn <= mtab[i][8];
            m = mtab[i][7:6];
            p = mtab[i][5:2];
            apb(1'h1, `ADCCH_IDX_CTRL, {6'h00, m});
            apb(1'h1, `ADCCH_IDX_MUX, {1'h0, p, 1'h0, mtab[i][1:0]});
            repeat (2) @(posedge pclk);
            pv = (m == 2'h1 || (mtab[i][8] && m == 2'h2)) ? p <= 4'hB
                : (mtab[i][8] && m == 2'h3 && p < 4'h8);
            iv = m == 2'h0 && p <= 4'h3;
            check({positive_pin_valid, internal_source_valid, negative_pin_valid,
                negative_pin}, {pv, iv, mtab[i][8] & m[1], m == 2'h3,
                mtab[i][1:0]});
            if (pv) check(positive_pin, p);
            if (iv) check(internal_source, p[1:0]);
        end
        // Every gain code in gained differential mode
        sgn <= 1'h1;
        for (int g = 0; g < 8; g++) begin
            apb(1'h1, `ADCCH_IDX_CTRL, {3'h0, g[2:0], 2'h3});
            repeat (2) @(posedge pclk);
            check({gain_select, gain_stage_on, input_source_mode},
                {g[2:0], g != 7, 2'h3});
        end
        final_report();
    end
endmodule
`default_nettype wire
